// *** rtl/eaad_map.vh ***
`ifndef EAAD_MAP_VH
`define EAAD_MAP_VH
// effective-address mode field codes
`define EAAD_MODE_DREG    3'h0
`define EAAD_MODE_AREG    3'h1
`define EAAD_MODE_IND     3'h2
`define EAAD_MODE_POSTINC 3'h3
`define EAAD_MODE_PREDEC  3'h4
`define EAAD_MODE_DISP    3'h5
`define EAAD_MODE_INDEX   3'h6
`define EAAD_MODE_SPECIAL 3'h7
// register subfield codes under the special mode
`define EAAD_SUB_ABS_SHORT 3'h0
`define EAAD_SUB_ABS_LONG  3'h1
`define EAAD_SUB_PC_DISP   3'h2
`define EAAD_SUB_PC_INDEX  3'h3
`define EAAD_SUB_IMMEDIATE 3'h4
// operation select codes
`define EAAD_OP_NONE       3'h0
`define EAAD_OP_DEC_BINARY_ADD_EXTEND   3'h1
`define EAAD_OP_BIN_BINARY_ADD_EXTEND   3'h2
`define EAAD_OP_ADD_IMM    3'h3
`define EAAD_OP_AND_FLAGS  3'h4
`define EAAD_OP_AND_STATUS 3'h5
`define EAAD_OP_BIT_INVERT 3'h6
`define EAAD_OP_BIT_ZERO   3'h7
// operand size codes
`define EAAD_SIZE_BYTE 2'h0
`define EAAD_SIZE_WORD 2'h1
`define EAAD_SIZE_LONG 2'h2
// flag positions in the status word
`define EAAD_FLAG_C 0
`define EAAD_FLAG_V 1
`define EAAD_FLAG_Z 2
`define EAAD_FLAG_N 3
`define EAAD_FLAG_X 4
// status word reset value: supervisor, mask 7, flags clear
`define EAAD_STATUS_RESET 16'h2700
// register file address map
`define EAAD_ADDR_STATUS  4'h0
`define EAAD_ADDR_EA      4'h1
`define EAAD_ADDR_CLASS   4'h2
`define EAAD_ADDR_OPCTRL  4'h3
`define EAAD_ADDR_SRCLO   4'h4
`define EAAD_ADDR_SRCHI   4'h5
`define EAAD_ADDR_DSTLO   4'h6
`define EAAD_ADDR_DSTHI   4'h7
`define EAAD_ADDR_RESLO   4'h8
`define EAAD_ADDR_RESHI   4'h9
`endif

// *** rtl/eaad_ea_class.v ***
`include "eaad_map.vh"
module eaad_ea_class (
	input  wire [2:0] eaMode,      // mode field
	input  wire [2:0] eaReg,       // register subfield
	output reg        isData,      // data category
	output reg        isMemory,    // memory category
	output reg        isControl,   // control category
	output reg        isAlterable, // alterable category
	output reg        isImmediate, // immediate data selected
	output reg        isIllegal,   // unused special code
	output wire       isAltMemory, // alterable and memory
	output wire       isDataAlt    // data and alterable
);
	always @* begin
		isData      = 1'b1;
		isMemory    = 1'b1;
		isControl   = 1'b0;
		isAlterable = 1'b1;
		isImmediate = 1'b0;
		isIllegal   = 1'b0;
		case (eaMode)
			`EAAD_MODE_DREG: begin
				isMemory = 1'b0;
			end
			`EAAD_MODE_AREG: begin
				isData   = 1'b0;
				isMemory = 1'b0;
			end
			`EAAD_MODE_IND, `EAAD_MODE_DISP, `EAAD_MODE_INDEX: begin
				isControl = 1'b1;
			end
			`EAAD_MODE_SPECIAL: begin
				case (eaReg)
					`EAAD_SUB_ABS_SHORT, `EAAD_SUB_ABS_LONG: begin
						isControl = 1'b1;
					end
					`EAAD_SUB_PC_DISP, `EAAD_SUB_PC_INDEX: begin
						isControl   = 1'b1;
						isAlterable = 1'b0;
					end
					`EAAD_SUB_IMMEDIATE: begin
						isImmediate = 1'b1;
						isAlterable = 1'b0;
					end
					default: begin
						isIllegal   = 1'b1;
						isData      = 1'b0;
						isMemory    = 1'b0;
						isAlterable = 1'b0;
					end
				endcase
			end
			default: begin
				isControl = 1'b0;
			end
		endcase
	end

	assign isAltMemory = isAlterable & isMemory;
	assign isDataAlt   = isData & isAlterable;
endmodule // eaad_ea_class

// *** rtl/eaad_bcd_add.v ***
module eaad_bcd_add (
	input  wire [7:0] dstVal,   // destination byte
	input  wire [7:0] srcVal,   // source byte
	input  wire       extIn,    // extend flag in
	output wire [7:0] sumVal,   // packed decimal sum
	output wire       carryOut  // decimal carry
);
	wire [4:0] loRaw;
	wire       loCarry;
	wire [4:0] loAdj;
	wire [4:0] hiRaw;
	wire [4:0] hiAdj;

	// low digit then high digit, each corrected by six past nine
	assign loRaw    = {1'b0, dstVal[3:0]} + {1'b0, srcVal[3:0]} + {4'h0, extIn};
	assign loCarry  = (loRaw > 5'h09);
	assign loAdj    = loCarry ? (loRaw + 5'h06) : loRaw;
	assign hiRaw    = {1'b0, dstVal[7:4]} + {1'b0, srcVal[7:4]} + {4'h0, loCarry};
	assign carryOut = (hiRaw > 5'h09);
	assign hiAdj    = carryOut ? (hiRaw + 5'h06) : hiRaw;
	assign sumVal   = {hiAdj[3:0], loAdj[3:0]};
endmodule // eaad_bcd_add

// *** rtl/eaad_decode.v ***
// Operation
// - mode field: 000-110 register, 111 special
// - special subfield: abs short/long, pc disp/index
// - data category excludes address register direct
// - memory category excludes both register directs
// - control: indirect, disp, index, abs, pc
// - pc-relative and immediate are not alterable
// - combined classes are ANDs of categories
// - decimal add: X,Z,C updated; N,V undefined
// - binary add extend updates all five flags
// - immediate/quick add updates all five flags
// - AND immediate byte into flag byte
// - AND immediate word into status word
// - bit invert: Z gets complement, bit flips
// - bit zero: Z gets complement, bit cleared
`include "eaad_map.vh"
module eaad_decode (
	input  wire        clk,     // core clock
	input  wire        rst,     // async reset, active high
	input  wire [3:0]  regAddr, // register address
	input  wire [15:0] wrData,  // write data
	input  wire        wrEn,    // write strobe
	input  wire        rdEn,    // read strobe
	output reg  [15:0] rdData   // read data, cycle after strobe
);
	reg  [15:0] status_q;
	reg  [5:0]  ea_q;
	reg  [2:0]  opSel_q;
	reg  [1:0]  opSize_q;
	reg  [4:0]  bitNum_q;
	reg  [31:0] src_q;
	reg  [31:0] dst_q;
	reg  [31:0] res_q;
	reg  [15:0] status_d;
	reg  [31:0] res_d;
	reg         start_q;
	reg         illegalOp_q;

	wire isData;
	wire isMemory;
	wire isControl;
	wire isAlterable;
	wire isImmediate;
	wire isIllegal;
	wire isAltMemory;
	wire isDataAlt;

	eaad_ea_class uClass (
		.eaMode      (ea_q[5:3]),
		.eaReg       (ea_q[2:0]),
		.isData      (isData),
		.isMemory    (isMemory),
		.isControl   (isControl),
		.isAlterable (isAlterable),
		.isImmediate (isImmediate),
		.isIllegal   (isIllegal),
		.isAltMemory (isAltMemory),
		.isDataAlt   (isDataAlt)
	);

	wire [7:0] bcdSum;
	wire       bcdCarry;

	eaad_bcd_add uBcd (
		.dstVal   (dst_q[7:0]),
		.srcVal   (src_q[7:0]),
		.extIn    (status_q[`EAAD_FLAG_X]),
		.sumVal   (bcdSum),
		.carryOut (bcdCarry)
	);

	// binary adder at full width; size picks the result bits
	wire        extBit = status_q[`EAAD_FLAG_X];
	wire        addCin = (opSel_q == `EAAD_OP_BIN_BINARY_ADD_EXTEND) ? extBit : 1'b0;
	wire [32:0] sum33  = {1'b0, dst_q} + {1'b0, src_q} + {32'h0, addCin};

	reg  [31:0] sizeMask;
	reg         sumMsb;
	reg         srcMsb;
	reg         dstMsb;
	reg         sumCarry;

	always @* begin
		case (opSize_q)
			`EAAD_SIZE_BYTE: begin
				sizeMask = 32'h000000FF;
				sumMsb   = sum33[7];
				srcMsb   = src_q[7];
				dstMsb   = dst_q[7];
				sumCarry = sum33[8] ^ src_q[8] ^ dst_q[8];
			end
			`EAAD_SIZE_WORD: begin
				sizeMask = 32'h0000FFFF;
				sumMsb   = sum33[15];
				srcMsb   = src_q[15];
				dstMsb   = dst_q[15];
				sumCarry = sum33[16] ^ src_q[16] ^ dst_q[16];
			end
			default: begin
				sizeMask = 32'hFFFFFFFF;
				sumMsb   = sum33[31];
				srcMsb   = src_q[31];
				dstMsb   = dst_q[31];
				sumCarry = sum33[32];
			end
		endcase
	end

	wire [31:0] sumMasked = sum33[31:0] & sizeMask;
	wire        sumOvf    = (srcMsb == dstMsb) && (sumMsb != srcMsb);
	wire [31:0] bitMask   = 32'h00000001 << bitNum_q;
	wire        selBit    = |(dst_q & bitMask);

	// one operation per start pulse; flags and result settle in one cycle
	always @* begin
		status_d = status_q;
		res_d    = res_q;
		if (start_q) begin
			case (opSel_q)
				`EAAD_OP_DEC_BINARY_ADD_EXTEND: begin
					res_d = {24'h0, bcdSum};
					status_d[`EAAD_FLAG_X] = bcdCarry;
					status_d[`EAAD_FLAG_C] = bcdCarry;
					// zero only clears; N and V left as they stand (undefined)
					if (bcdSum != 8'h00) begin
						status_d[`EAAD_FLAG_Z] = 1'b0;
					end
				end
				`EAAD_OP_BIN_BINARY_ADD_EXTEND: begin
					res_d = sumMasked;
					status_d[`EAAD_FLAG_X] = sumCarry;
					status_d[`EAAD_FLAG_C] = sumCarry;
					status_d[`EAAD_FLAG_N] = sumMsb;
					status_d[`EAAD_FLAG_V] = sumOvf;
					if (sumMasked != 32'h0) begin
						status_d[`EAAD_FLAG_Z] = 1'b0;
					end
				end
				`EAAD_OP_ADD_IMM: begin
					res_d = sumMasked;
					status_d[`EAAD_FLAG_X] = sumCarry;
					status_d[`EAAD_FLAG_C] = sumCarry;
					status_d[`EAAD_FLAG_N] = sumMsb;
					status_d[`EAAD_FLAG_V] = sumOvf;
					status_d[`EAAD_FLAG_Z] = (sumMasked == 32'h0);
				end
				`EAAD_OP_AND_FLAGS: begin
					status_d[7:0] = status_q[7:0] & src_q[7:0];
				end
				`EAAD_OP_AND_STATUS: begin
					status_d = status_q & src_q[15:0];
				end
				`EAAD_OP_BIT_INVERT: begin
					status_d[`EAAD_FLAG_Z] = ~selBit;
					res_d = dst_q ^ bitMask;
				end
				`EAAD_OP_BIT_ZERO: begin
					status_d[`EAAD_FLAG_Z] = ~selBit;
					res_d = dst_q & ~bitMask;
				end
				default: begin
					res_d = res_q;
				end
			endcase
		end
	end

	// operations needing a writeable destination refuse modes that are not data alterable
	wire needsAlt = (opSel_q == `EAAD_OP_ADD_IMM) || (opSel_q == `EAAD_OP_BIT_INVERT)
		|| (opSel_q == `EAAD_OP_BIT_ZERO);
	wire refuse   = start_q && (isIllegal || (needsAlt && !isDataAlt));

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q    <= `EAAD_STATUS_RESET;
			ea_q        <= 6'h00;
			opSel_q     <= 3'h0;
			opSize_q    <= 2'h0;
			bitNum_q    <= 5'h00;
			src_q       <= 32'h0;
			dst_q       <= 32'h0;
			res_q       <= 32'h0;
			start_q     <= 1'b0;
			illegalOp_q <= 1'b0;
		end else begin
			start_q <= wrEn && (regAddr == `EAAD_ADDR_OPCTRL) && wrData[15];
			if (refuse) begin
				illegalOp_q <= 1'b1;
			end else begin
				status_q <= status_d;
				res_q    <= res_d;
			end
			if (wrEn) begin
				case (regAddr)
					`EAAD_ADDR_STATUS: status_q <= wrData;
					`EAAD_ADDR_EA:     ea_q <= wrData[5:0];
					`EAAD_ADDR_OPCTRL: begin
						opSel_q     <= wrData[2:0];
						opSize_q    <= wrData[5:4];
						bitNum_q    <= wrData[12:8];
						// a refusal landing on the same edge wins over the clear
						illegalOp_q <= refuse;
					end
					`EAAD_ADDR_SRCLO: src_q[15:0] <= wrData;
					`EAAD_ADDR_SRCHI: src_q[31:16] <= wrData;
					`EAAD_ADDR_DSTLO: dst_q[15:0] <= wrData;
					`EAAD_ADDR_DSTHI: dst_q[31:16] <= wrData;
					default: begin
						ea_q <= ea_q;
					end
				endcase
			end
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData <= 16'h0000;
		end else if (rdEn) begin
			case (regAddr)
				`EAAD_ADDR_STATUS: rdData <= status_q;
				`EAAD_ADDR_EA:     rdData <= {10'h000, ea_q};
				`EAAD_ADDR_CLASS:  rdData <= {8'h00, isDataAlt, isAltMemory, isIllegal,
					isImmediate, isAlterable, isControl, isMemory, isData};
				`EAAD_ADDR_OPCTRL: rdData <= {start_q, illegalOp_q, 1'b0, bitNum_q, 2'h0,
					opSize_q, 1'b0, opSel_q};
				`EAAD_ADDR_SRCLO:  rdData <= src_q[15:0];
				`EAAD_ADDR_SRCHI:  rdData <= src_q[31:16];
				`EAAD_ADDR_DSTLO:  rdData <= dst_q[15:0];
				`EAAD_ADDR_DSTHI:  rdData <= dst_q[31:16];
				`EAAD_ADDR_RESLO:  rdData <= res_q[15:0];
				`EAAD_ADDR_RESHI:  rdData <= res_q[31:16];
				default:           rdData <= 16'h0000;
			endcase
		end else begin
			rdData <= 16'h0000;
		end
	end
endmodule // eaad_decode

// *** verification/eaad_decode_checker.sv ***
module eaad_decode_checker (
	input wire        clk,     // clock
	input wire        rst,     // reset
	input wire [3:0]  regAddr, // address
	input wire [15:0] wrData,  // write data
	input wire        wrEn,    // write strobe
	input wire        rdEn,    // read strobe
	input wire [15:0] rdData   // read data
);
	timeunit 1ns;
	timeprecision 1ps;
	reg  [5:0] eaQ;
	wire [2:0] md  = eaQ[5:3];
	wire [2:0] sb  = eaQ[2:0];
	wire       sp  = md == 3'h7;
	wire       ill = sp && sb > 3'h4;
	wire       dat = md != 3'h1 && !ill;
	wire       mem = md > 3'h1 && !ill;
	wire       ctl = md == 3'h2 || md == 3'h5 || md == 3'h6 || (sp && sb < 3'h4);
	wire       alt = !sp || sb < 3'h2;
	wire       rdCls = rdEn && regAddr == 4'h2;
	// shadow of the mode register
	always @(posedge clk or posedge rst) begin
		if (rst)
			eaQ <= 6'h00;
		else if (wrEn && regAddr == 4'h1)
			eaQ <= wrData[5:0];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_idle; !rdEn |=> rdData == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data not zero");
	property p_unmapped; rdEn && regAddr > 4'h9 |=> rdData == 16'h0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_ea; rdEn && regAddr == 4'h1 |=> rdData[5:0] == $past(eaQ); endproperty
	a_ea: assert property (p_ea) else $error("mode readback");
	property p_data; rdCls |=> rdData[0] == $past(dat); endproperty
	a_data: assert property (p_data) else $error("data class");
	property p_mem; rdCls |=> rdData[1] == $past(mem); endproperty
	a_mem: assert property (p_mem) else $error("memory class");
	property p_ctl; rdCls |=> rdData[2] == $past(ctl); endproperty
	a_ctl: assert property (p_ctl) else $error("control class");
	property p_alt; rdCls |=> rdData[3] == $past(alt && !ill); endproperty
	a_alt: assert property (p_alt) else $error("alterable class");
	property p_imm; rdCls |=> rdData[5:4] == $past({ill, sp && sb == 3'h4}); endproperty
	a_imm: assert property (p_imm) else $error("immediate or illegal");
	property p_comb;
		rdCls |=> rdData[7:6] == $past({dat && alt && !ill, mem && alt});
	endproperty
	a_comb: assert property (p_comb) else $error("combined class");
	cover property (rdCls);
	cover property (wrEn && regAddr == 4'h3 && wrData[15]);
	cover property (rdEn && regAddr == 4'h0);
endmodule // eaad_decode_checker

// *** verification/eaad_decode_tb.sv ***
module eaad_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg         clk;
	reg         rst;
	reg         wrEn;
	reg         rdEn;
	reg  [3:0]  regAddr;
	reg  [15:0] wrData;
	wire [15:0] rdData;
	int         badCount;
	int         testsRun;
	int         i;
	eaad_decode uut (.clk(clk), .rst(rst), .regAddr(regAddr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic [7:0] cls(input [5:0] x);
		logic sp, il, d, m, c, a;
		sp = x[5:3] == 3'h7;
		il = sp && x[2:0] > 3'h4;
		d = x[5:3] != 3'h1 && !il;
		m = x[5:3] > 3'h1 && !il;
		c = (x[5:3] == 3'h2) || (x[5:3] == 3'h5) || (x[5:3] == 3'h6) || (sp && x[2:0] < 3'h4);
		a = (!sp || x[2:0] < 3'h2) && !il;
		return {d && a, m && a, il, sp && x[2:0] == 3'h4, a, c, m, d};
	endfunction
	task automatic wr(input [3:0] a, input [15:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		regAddr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input [3:0] a, input [15:0] exp, input [15:0] msk);
		@(posedge clk);
		rdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		testsRun++;
		if ((rdData & msk) !== exp) begin
			badCount++;
			$display("mismatch reg %0h expected %h seen %h", a, exp, rdData & msk);
		end
	endtask
	// operands, start, then status and result
	task automatic run(input [15:0] ctl, src, dst, st, expSt, expRes, resMsk);
		wr(4'h4, src);
		wr(4'h6, dst);
		wr(4'h0, st);
		wr(4'h3, ctl);
		rd(4'h0, expSt, 16'hFFFF);
		rd(4'h8, expRes, resMsk);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		badCount++;
		end_of_test;
	end
	initial begin
		rst = 1'b1;
		wrEn = 1'b0;
		rdEn = 1'b0;
		regAddr = 4'h0;
		wrData = 16'h0000;
		badCount = 0;
		testsRun = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(4'h0, 16'h2700, 16'hFFFF);
		rd(4'h2, 16'h0089, 16'hFFFF);
		rd(4'hF, 16'h0000, 16'hFFFF);
		for (i = 0; i < 64; i++) begin
			wr(4'h1, i[15:0]);
			wr(4'h2, 16'hFFFF);
			rd(4'h2, {8'h00, cls(i[5:0])}, 16'hFFFF);
			rd(4'h1, i[15:0], 16'h003F);
		end
		wr(4'h1, 16'h0000);
		run(16'h8012, 16'h7FFF, 16'h0001, 16'h2700, 16'h270A, 16'h8000, 16'hFFFF);
		run(16'h8001, 16'h0055, 16'h0055, 16'h2714, 16'h2711, 16'h0011, 16'h00FF);
		run(16'h8003, 16'h00FF, 16'h0001, 16'h2700, 16'h2715, 16'h0000, 16'h00FF);
		run(16'h8004, 16'h000A, 16'h0000, 16'h271F, 16'h270A, 16'h0000, 16'hFFFF);
		run(16'h8015, 16'h2704, 16'h0000, 16'hA71F, 16'h2704, 16'h0000, 16'hFFFF);
		run(16'h8026, 16'h0000, 16'h0000, 16'h2700, 16'h2704, 16'h0001, 16'hFFFF);
		run(16'h8427, 16'h0000, 16'h0030, 16'h271F, 16'h271B, 16'h0020, 16'hFFFF);
		wr(4'h1, 16'h003C);
		run(16'h8003, 16'h00FF, 16'h0001, 16'h2700, 16'h2700, 16'h0020, 16'hFFFF);
		rd(4'h3, 16'h4000, 16'h4000);
		// long extend add through the upper halves, carry and overflow out
		wr(4'h5, 16'h8000);
		wr(4'h7, 16'h8001);
		rd(4'h5, 16'h8000, 16'hFFFF);
		rd(4'h7, 16'h8001, 16'hFFFF);
		run(16'h8022, 16'h0000, 16'h0000, 16'h2714, 16'h2713, 16'h0001, 16'hFFFF);
		rd(4'h9, 16'h0001, 16'hFFFF);
		rd(4'h3, 16'h0000, 16'h4000);
		end_of_test;
	end
endmodule // eaad_decode_tb
bind eaad_decode eaad_decode_checker chk (.clk(clk), .rst(rst), .regAddr(regAddr),
	.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));
